/* src/iwce_engine.sv */
// serial-bus target command engine for a two-wiper digital potentiometer
// assumes scl and sda arrive asynchronously and an open-drain bus outside
module iwce_engine (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic       bus_addr_bit_low_in,
    input  wire logic       high_voltage_cmd_select_in,
    input  wire logic       resolution_8bit_in,
    input  wire logic       nv_write_busy_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    output logic [8:0]      wiper_zero_setting_out,
    output logic [8:0]      wiper_one_setting_out,
    output logic [8:0]      term_ctrl_out,
    output logic            hv_cmd_out
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [2:0]            scl_sync;
        logic [2:0]            sda_sync;
        logic [2:0]            hv_sync;
        logic [2:0]            a0_sync;
        logic                  scl;
        logic                  sda;
        logic                  hv;
        logic                  a0;
        iwce_pkg::iwce_state_e st;
        logic [3:0]            bit_cnt;
        logic [7:0]            shreg;
        logic [1:0]            cmd_op;
        logic [3:0]            ptr;
        logic                  d8;
        logic                  rw;
        logic                  low_next;
        logic                  ack_ok;
        logic                  oe;
        logic                  hv_mode;
        logic [8:0]            wiper0;
        logic [8:0]            wiper1;
        logic [8:0]            tcon;
    } iwce_state_s;

    iwce_state_s s;
    iwce_state_s next_s;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_seen;
    logic        stop_seen;
    logic [8:0]  full_scale;
    logic [8:0]  rd_word;

    // a new level counts only once the second and third flops agree
    function automatic logic agreed(input logic [2:0] sync, input logic cur);
        return (sync[1] == sync[2]) ? sync[2] : cur;
    endfunction

    function automatic logic cmd_valid(input logic [3:0] loc, input logic [1:0] op,
                                       input logic busy);
        logic ok;
        ok = 1'b0;
        unique case (op)
            iwce_pkg::OP_WRITE: ok = (loc == iwce_pkg::LOC_WIPER_ZERO) ||
                                     (loc == iwce_pkg::LOC_WIPER_ONE)  ||
                                     (loc == iwce_pkg::LOC_TERM_CTRL);
            iwce_pkg::OP_INC:   ok = (loc == iwce_pkg::LOC_WIPER_ZERO) ||
                                     (loc == iwce_pkg::LOC_WIPER_ONE);
            // decrement is not carried by this engine and is refused
            iwce_pkg::OP_DEC:   ok = 1'b0;
            // status maps to nonvolatile state: no reads of it while busy
            iwce_pkg::OP_READ:  ok = (loc == iwce_pkg::LOC_WIPER_ZERO) ||
                                     (loc == iwce_pkg::LOC_WIPER_ONE)  ||
                                     (loc == iwce_pkg::LOC_TERM_CTRL)  ||
                                     (loc == iwce_pkg::LOC_STATUS && !busy);
        endcase
        return ok;
    endfunction

    // ****************************************************************
    // bus conditions
    // ****************************************************************
    // edges come straight from the synchronisers, not from next_s, so no loop
    always_comb begin
        scl_rise   = !s.scl && agreed(s.scl_sync, s.scl);
        scl_fall   = s.scl && !agreed(s.scl_sync, s.scl);
        start_seen = s.scl && agreed(s.scl_sync, s.scl) && s.sda && !agreed(s.sda_sync, s.sda);
        stop_seen  = s.scl && agreed(s.scl_sync, s.scl) && !s.sda && agreed(s.sda_sync, s.sda);
        full_scale = resolution_8bit_in ? iwce_pkg::FULL_SCALE_8 : iwce_pkg::FULL_SCALE_7;
        unique case (s.ptr)
            iwce_pkg::LOC_WIPER_ONE: rd_word = s.wiper1;
            iwce_pkg::LOC_TERM_CTRL: rd_word = s.tcon;
            iwce_pkg::LOC_STATUS:    rd_word = {iwce_pkg::STATUS_PAD, nv_write_busy_in};
            default:                 rd_word = s.wiper0;
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_s          = s;
        next_s.scl_sync = {s.scl_sync[1:0], scl_in};
        next_s.sda_sync = {s.sda_sync[1:0], sda_in};
        next_s.hv_sync  = {s.hv_sync[1:0], high_voltage_cmd_select_in};
        next_s.a0_sync  = {s.a0_sync[1:0], bus_addr_bit_low_in};
        next_s.scl      = agreed(s.scl_sync, s.scl);
        next_s.sda      = agreed(s.sda_sync, s.sda);
        next_s.hv       = agreed(s.hv_sync, s.hv);
        next_s.a0       = agreed(s.a0_sync, s.a0);

        if (!s.scl && next_s.scl) begin
            next_s.bit_cnt = s.bit_cnt + iwce_pkg::BIT_STEP;
        end

        if (start_seen) begin
            // restart mid byte drops the partial byte; pointer untouched
            next_s.st      = iwce_pkg::ST_CTRL;
            next_s.bit_cnt = '0;
            next_s.oe      = 1'b0;
        end else if (stop_seen) begin
            next_s.st = iwce_pkg::ST_IDLE;
            next_s.oe = 1'b0;
        end else begin
            unique case (s.st)
                iwce_pkg::ST_IDLE, iwce_pkg::ST_IGNORE: begin
                    next_s.oe = 1'b0;
                end
                iwce_pkg::ST_CTRL: begin
                    if (scl_rise) begin
                        next_s.shreg = {s.shreg[6:0], s.sda};
                    end else if (scl_fall && s.bit_cnt == iwce_pkg::BITS_PER_BYTE) begin
                        // a high-voltage level on the shared pin reads as a one
                        if (s.shreg[7:1] == {iwce_pkg::CTRL_ADDR_HI, s.a0 | s.hv}) begin
                            next_s.oe = 1'b1;
                            next_s.rw = s.shreg[0];
                            next_s.st = iwce_pkg::ST_CTRL_ACK;
                        end else begin
                            next_s.st = iwce_pkg::ST_IGNORE;
                        end
                    end
                end
                iwce_pkg::ST_CTRL_ACK: begin
                    if (scl_fall) begin
                        next_s.bit_cnt = '0;
                        if (s.rw) begin
                            // high byte first, then low byte
                            next_s.shreg    = {iwce_pkg::HIGH_PAD, rd_word[8]};
                            next_s.oe       = 1'b1;
                            next_s.low_next = 1'b1;
                            next_s.st       = iwce_pkg::ST_TX;
                        end else begin
                            next_s.oe = 1'b0;
                            next_s.st = iwce_pkg::ST_CMD;
                        end
                    end
                end
                iwce_pkg::ST_CMD: begin
                    if (scl_rise) begin
                        next_s.shreg = {s.shreg[6:0], s.sda};
                    end else if (scl_fall && s.bit_cnt == iwce_pkg::BITS_PER_BYTE) begin
                        if (cmd_valid(s.shreg[iwce_pkg::LOC_HI:iwce_pkg::LOC_LO],
                                      s.shreg[iwce_pkg::OP_HI:iwce_pkg::OP_LO],
                                      nv_write_busy_in)) begin
                            next_s.oe      = 1'b1;
                            next_s.ptr     = s.shreg[iwce_pkg::LOC_HI:iwce_pkg::LOC_LO];
                            next_s.cmd_op  = s.shreg[iwce_pkg::OP_HI:iwce_pkg::OP_LO];
                            next_s.d8      = s.shreg[iwce_pkg::MSB_BIT];
                            next_s.hv_mode = s.hv;
                            next_s.st      = iwce_pkg::ST_CMD_ACK;
                        end else begin
                            next_s.oe = 1'b0;
                            next_s.st = iwce_pkg::ST_IGNORE;
                        end
                    end
                end
                iwce_pkg::ST_CMD_ACK: begin
                    if (scl_rise && s.cmd_op == iwce_pkg::OP_INC) begin
                        // values at or above full scale, reserved ones too, hold
                        if (s.ptr == iwce_pkg::LOC_WIPER_ZERO && s.wiper0 < full_scale) begin
                            next_s.wiper0 = s.wiper0 + iwce_pkg::WIPER_STEP;
                        end
                        if (s.ptr == iwce_pkg::LOC_WIPER_ONE && s.wiper1 < full_scale) begin
                            next_s.wiper1 = s.wiper1 + iwce_pkg::WIPER_STEP;
                        end
                    end else if (scl_fall) begin
                        next_s.oe      = 1'b0;
                        next_s.bit_cnt = '0;
                        next_s.st      = (s.cmd_op == iwce_pkg::OP_WRITE) ? iwce_pkg::ST_DATA
                                                                          : iwce_pkg::ST_CMD;
                    end
                end
                iwce_pkg::ST_DATA: begin
                    if (scl_rise) begin
                        next_s.shreg = {s.shreg[6:0], s.sda};
                    end else if (scl_fall && s.bit_cnt == iwce_pkg::BITS_PER_BYTE) begin
                        next_s.oe = 1'b1;
                        next_s.st = iwce_pkg::ST_DATA_ACK;
                    end
                end
                iwce_pkg::ST_DATA_ACK: begin
                    if (scl_rise) begin
                        unique case (s.ptr)
                            iwce_pkg::LOC_WIPER_ZERO: next_s.wiper0 = {s.d8, s.shreg};
                            iwce_pkg::LOC_WIPER_ONE:  next_s.wiper1 = {s.d8, s.shreg};
                            default:                  next_s.tcon   = {s.d8, s.shreg};
                        endcase
                    end else if (scl_fall) begin
                        next_s.oe      = 1'b0;
                        next_s.bit_cnt = '0;
                        next_s.st      = iwce_pkg::ST_CMD;
                    end
                end
                iwce_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (s.bit_cnt == iwce_pkg::BITS_PER_BYTE) begin
                            next_s.oe = 1'b0;
                            next_s.st = iwce_pkg::ST_TX_ACK;
                        end else begin
                            next_s.shreg = {s.shreg[6:0], 1'b0};
                            next_s.oe    = !s.shreg[6];
                        end
                    end
                end
                iwce_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        next_s.ack_ok = !s.sda;
                    end else if (scl_fall) begin
                        next_s.bit_cnt = '0;
                        if (s.ack_ok) begin
                            // each acked pair re-reads the pointed word
                            next_s.shreg    = s.low_next ? rd_word[7:0]
                                                         : {iwce_pkg::HIGH_PAD, rd_word[8]};
                            next_s.oe       = s.low_next ? !rd_word[7] : 1'b1;
                            next_s.low_next = !s.low_next;
                            next_s.st       = iwce_pkg::ST_TX;
                        end else begin
                            next_s.oe = 1'b0;
                            next_s.st = iwce_pkg::ST_IGNORE;
                        end
                    end
                end
                default: begin
                    next_s.oe = 1'b0;
                    next_s.st = iwce_pkg::ST_IGNORE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s            <= '0;
            // bus idles high: flops start there so no false edge follows reset
            s.scl_sync   <= '1;
            s.sda_sync   <= '1;
            s.scl        <= 1'b1;
            s.sda        <= 1'b1;
            s.st         <= iwce_pkg::ST_IDLE;
            s.ptr        <= iwce_pkg::PTR_RESET;
            s.wiper0     <= iwce_pkg::WIPER_RESET;
            s.wiper1     <= iwce_pkg::WIPER_RESET;
            s.tcon       <= iwce_pkg::TERM_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign sda_out                = 1'b0;
    assign sda_oe_out             = s.oe;
    assign wiper_zero_setting_out = s.wiper0;
    assign wiper_one_setting_out  = s.wiper1;
    assign term_ctrl_out          = s.tcon;
    assign hv_cmd_out             = s.hv_mode;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    sequence released_two;
        !s.oe [*2];
    endsequence

    data_commit_a: assert property (
        (s.st == iwce_pkg::ST_DATA_ACK && scl_rise && s.ptr == iwce_pkg::LOC_WIPER_ZERO)
        |=> s.wiper0 == {$past(s.d8), $past(s.shreg)})
        else $error("data byte not committed on ack clock");
    abort_keep_a: assert property (
        (s.st == iwce_pkg::ST_DATA && (start_seen || stop_seen))
        |=> ($stable(s.wiper0) && $stable(s.wiper1) && $stable(s.tcon)))
        else $error("aborted byte changed a location");
    cont_write_a: assert property (
        (s.st == iwce_pkg::ST_DATA_ACK && scl_fall && !start_seen && !stop_seen)
        |=> s.st == iwce_pkg::ST_CMD)
        else $error("no command expected after data ack");
    ptr_keep_a: assert property (
        (start_seen || stop_seen) |=> $stable(s.ptr))
        else $error("pointer changed on start or stop");
    ignore_quiet_a: assert property (
        s.st == iwce_pkg::ST_IGNORE |-> !s.oe)
        else $error("sda driven while ignoring bus");
    nack_release_a: assert property (
        (s.st == iwce_pkg::ST_TX_ACK && scl_fall && !s.ack_ok && !start_seen)
        |=> released_two)
        else $error("sda not released after master nack");
    cmd_nack_a: assert property (
        (s.st == iwce_pkg::ST_CMD && scl_fall && s.bit_cnt == iwce_pkg::BITS_PER_BYTE
         && !start_seen && !stop_seen && !next_s.oe)
        |=> (s.st == iwce_pkg::ST_IGNORE && !s.oe))
        else $error("invalid command byte acknowledged");
    inc_step_a: assert property (
        (s.st == iwce_pkg::ST_CMD_ACK && scl_rise && !start_seen && !stop_seen
         && s.cmd_op == iwce_pkg::OP_INC && s.ptr == iwce_pkg::LOC_WIPER_ZERO)
        |=> s.wiper0 == (($past(s.wiper0) < $past(full_scale))
                         ? 9'($past(s.wiper0) + iwce_pkg::WIPER_STEP) : $past(s.wiper0)))
        else $error("increment wrong or not saturated");

endmodule

/* src/iwce_pkg.sv */
// constants shared by the wiper command engine and its bench
// assumes a single 100 MHz system clock samples the serial bus pins
package iwce_pkg;

    // ****************************************************************
    // state machine
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_CTRL     = 4'h1,
        ST_CTRL_ACK = 4'h2,
        ST_CMD      = 4'h3,
        ST_CMD_ACK  = 4'h4,
        ST_DATA     = 4'h5,
        ST_DATA_ACK = 4'h6,
        ST_TX       = 4'h7,
        ST_TX_ACK   = 4'h8,
        ST_IGNORE   = 4'h9
    } iwce_state_e;

    // ****************************************************************
    // command byte layout and operation codes
    // ****************************************************************
    localparam int         LOC_HI     = 7;
    localparam int         LOC_LO     = 4;
    localparam int         OP_HI      = 3;
    localparam int         OP_LO      = 2;
    localparam int         MSB_BIT    = 0;
    localparam logic [1:0] OP_WRITE   = 2'h0;
    localparam logic [1:0] OP_INC     = 2'h1;
    localparam logic [1:0] OP_DEC     = 2'h2;
    localparam logic [1:0] OP_READ    = 2'h3;

    // ****************************************************************
    // memory map
    // ****************************************************************
    localparam logic [3:0] LOC_WIPER_ZERO = 4'h0;
    localparam logic [3:0] LOC_WIPER_ONE  = 4'h1;
    localparam logic [3:0] LOC_TERM_CTRL  = 4'h4;
    localparam logic [3:0] LOC_STATUS     = 4'h5;

    // ****************************************************************
    // values, limits and bus constants
    // ****************************************************************
    localparam logic [8:0] WIPER_RESET   = 9'h080;
    localparam logic [8:0] TERM_RESET    = 9'h1FF;
    localparam logic [8:0] FULL_SCALE_8  = 9'h100;
    localparam logic [8:0] FULL_SCALE_7  = 9'h080;
    localparam logic [8:0] WIPER_STEP    = 9'h001;
    localparam logic [3:0] PTR_RESET     = 4'h0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_STEP      = 4'h1;
    // control address upper six bits; value is arbitrary
    localparam logic [5:0] CTRL_ADDR_HI  = 6'h2E;
    localparam logic [6:0] HIGH_PAD      = 7'h00;
    localparam logic [7:0] STATUS_PAD    = 8'h00;

endpackage

/* verification/iwce_bus_master.sv */
// serial bus master model driving the wiper command engine
// assumes a pull-up on sda outside; scl rests high between frames
module iwce_bus_master (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out,
    output logic      hv_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // bus cycles, 16 system clocks per bit
    // ****************************************************************
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
        hv_out = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // settle time before the first scl edge after raising the flag
    task automatic hv(input logic v);
        hv_out = v;
        tick(16);
    endtask
    task automatic pulse(output logic s);
        scl_out = 1'b1;
        tick(4);
        s = sda_in;
        tick(4);
        scl_out = 1'b0;
        tick(4);
    endtask
    task automatic start();
        sda_low_out = 1'b0;
        tick(4);
        scl_out = 1'b1;
        tick(4);
        sda_low_out = 1'b1;
        tick(4);
        scl_out = 1'b0;
        tick(4);
    endtask
    task automatic stop();
        sda_low_out = 1'b1;
        tick(4);
        scl_out = 1'b1;
        tick(4);
        sda_low_out = 1'b0;
        tick(8);
    endtask
    // fewer than eight bits leaves the byte unfinished, no ack clock
    task automatic wr(input logic [7:0] b, input int n, output logic ack);
        logic s;
        for (int i = 0; i < n; i++) begin
            sda_low_out = ~b[7-i];
            tick(4);
            pulse(s);
        end
        ack = 1'b0;
        if (n == 8) begin
            sda_low_out = 1'b0;
            tick(4);
            pulse(s);
            ack = ~s;
        end
    endtask
    task automatic rd(input logic ack, output logic [7:0] b);
        logic s;
        sda_low_out = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            tick(4);
            pulse(s);
            b[i] = s;
        end
        sda_low_out = ack;
        tick(4);
        pulse(s);
        sda_low_out = 1'b0;
    endtask
endmodule

/* verification/tb.sv */
// self-checking bench for the wiper command engine
// assumes the bus master model and an open-drain sda with pull-up
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_in = 1'b0;
    logic       reset_in = 1'b1;
    logic       a0 = 1'b0;
    logic       res8 = 1'b1;
    logic       busy = 1'b0;
    logic       scl, sda_low, hv, oe, hvo, k, sdo;
    logic [8:0] w0o, w1o, tco;
    logic [7:0] b;
    wire        sda = ~sda_low & (oe ? sdo : 1'b1);
    int         w[6];
    int         ptr;
    int         err_total = 0;
    int         checks = 0;
    initial forever #5 clk_in = ~clk_in;
    iwce_engine u_iwce_engine (.clk_in(clk_in), .reset_in(reset_in), .scl_in(scl),
        .sda_in(sda), .bus_addr_bit_low_in(a0), .high_voltage_cmd_select_in(hv),
        .resolution_8bit_in(res8), .nv_write_busy_in(busy), .sda_out(sdo),
        .sda_oe_out(oe), .wiper_zero_setting_out(w0o), .wiper_one_setting_out(w1o),
        .term_ctrl_out(tco), .hv_cmd_out(hvo));
    iwce_bus_master u_m (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
        .sda_low_out(sda_low), .hv_out(hv));
    // ****************************************************************
    // compare and bus tasks
    // ****************************************************************
    task automatic chk(input logic [8:0] a, input int e, input string m);
        checks++;
        if (a !== 9'(e)) begin
            err_total++;
            $display("Error at %0t: %s got %h expected %h", $time, m, a, e);
        end
    endtask
    task automatic regs();
        chk(w0o, w[0], "wiper zero");
        chk(w1o, w[1], "wiper one");
        chk(tco, w[4], "term ctrl");
    endtask
    task automatic ctrl(input logic a, input logic rw, input int e);
        u_m.start();
        u_m.wr({iwce_pkg::CTRL_ADDR_HI, a, rw}, 8, k);
        chk({8'h00, k}, e, "ctrl ack");
    endtask
    // expected ack e; a write sends its data byte, an inc saturates
    task automatic cmd(input int loc, input logic [1:0] op, input int v, input int e);
        int fs;
        fs = res8 ? 256 : 128;
        u_m.wr({4'(loc), op, 1'b0, v[8]}, 8, k);
        chk({8'h00, k}, e, "cmd ack");
        if (e != 0 && op == iwce_pkg::OP_WRITE) begin
            u_m.wr(v[7:0], 8, k);
            chk({8'h00, k}, 1, "data ack");
            w[loc] = v;
        end
        if (e != 0) ptr = loc;
        if (e != 0 && op == iwce_pkg::OP_INC && w[loc] < fs) w[loc]++;
        regs();
    endtask
    task automatic rdw(input logic last);
        logic [7:0] h;
        u_m.rd(1'b1, h);
        u_m.rd(~last, b);
        chk({h[0], b}, w[ptr], "read word");
        chk({2'b00, h[7:1]}, 0, "high pad");
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        #300us;
        err_total++;
        end_of_test();
    end
    initial begin
        void'($urandom(16376));
        w = '{128, 128, 0, 0, 511, 0};
        ptr = 0;
        repeat (8) @(posedge clk_in);
        #1 reset_in = 1'b0;
        u_m.tick(8);
        regs();
        ctrl(0, 1, 1);
        rdw(1);
        u_m.stop();
        $display("test 1 done");
        ctrl(0, 0, 1);
        foreach (w[i]) if (i < 2 || i == 4) cmd(i, iwce_pkg::OP_WRITE, $urandom % 512, 1);
        u_m.stop();
        ctrl(0, 1, 1);
        rdw(1);
        u_m.stop();
        $display("test 2 done");
        ctrl(0, 0, 1);
        u_m.wr(8'h00, 8, k);
        ptr = 0;
        u_m.wr(8'h3C, 5, k);
        u_m.stop();
        regs();
        $display("test 3 done");
        for (int r = 1; r >= 0; r--) begin
            res8 = r[0];
            ctrl(0, 0, 1);
            cmd(0, iwce_pkg::OP_WRITE, (r ? 256 : 128) - 1, 1);
            cmd(0, iwce_pkg::OP_INC, 0, 1);
            cmd(0, iwce_pkg::OP_INC, 0, 1);
            cmd(1, iwce_pkg::OP_WRITE, (r ? 256 : 128) + 1, 1);
            cmd(1, iwce_pkg::OP_INC, 0, 1);
            cmd(r ? 4 : 0, r ? iwce_pkg::OP_INC : iwce_pkg::OP_DEC, 0, 0);
            cmd(1, iwce_pkg::OP_WRITE, 5, 0);
            u_m.stop();
        end
        $display("test 4 done");
        ctrl(0, 0, 1);
        cmd(4, iwce_pkg::OP_READ, 0, 1);
        ctrl(0, 1, 1);
        rdw(0);
        rdw(1);
        u_m.rd(1'b0, b);
        chk({1'b0, b}, 255, "released");
        u_m.stop();
        ctrl(0, 1, 1);
        rdw(1);
        u_m.stop();
        $display("test 5 done");
        busy = 1'b1;
        ctrl(0, 0, 1);
        cmd(5, iwce_pkg::OP_READ, 0, 0);
        u_m.stop();
        busy = 1'b0;
        ctrl(0, 0, 1);
        cmd(5, iwce_pkg::OP_READ, 0, 1);
        ctrl(0, 1, 1);
        rdw(1);
        u_m.stop();
        $display("test 6 done");
        ctrl(1, 0, 0);
        u_m.stop();
        u_m.hv(1'b1);
        ctrl(1, 0, 1);
        cmd(1, iwce_pkg::OP_WRITE, $urandom % 512, 1);
        chk({8'h00, hvo}, 1, "hv flag");
        u_m.stop();
        u_m.hv(1'b0);
        a0 = 1'b1;
        ctrl(1, 0, 1);
        cmd(0, iwce_pkg::OP_READ, 0, 1);
        chk({8'h00, hvo}, 0, "hv flag");
        u_m.stop();
        $display("test 7 done");
        reset_in = 1'b1;
        u_m.tick(2);
        reset_in = 1'b0;
        w = '{128, 128, 0, 0, 511, 0};
        ptr = 0;
        u_m.tick(8);
        regs();
        chk({8'h00, hvo}, 0, "hv flag");
        ctrl(1, 1, 1);
        rdw(1);
        u_m.stop();
        $display("test 8 done");
        end_of_test();
    end
endmodule
